/* File: rtl/ccsr_regs.svh */
// Register indices, field positions, reset values and sizes
`ifndef CCSR_REGS_SVH
`define CCSR_REGS_SVH
`define CCSR_IDX_SP      8'h81
`define CCSR_IDX_POINTER0_LOW_BYTE    8'h82
`define CCSR_IDX_POINTER0_HIGH_BYTE    8'h83
`define CCSR_IDX_POINTER1_LOW_BYTE    8'h84
`define CCSR_IDX_POINTER1_HIGH_BYTE    8'h85
`define CCSR_IDX_PAGE    8'h86
`define CCSR_IDX_AUX     8'h8E
`define CCSR_IDX_PSW     8'hD0
`define CCSR_IDX_ACC     8'hE0
`define CCSR_IDX_OPND    8'hF0
`define CCSR_RST_SP      8'h07
`define CCSR_RST_ZERO    8'h00
`define CCSR_PAGE_BASE   8'hF0
`define CCSR_PSW_CY      7
`define CCSR_PSW_AC      6
`define CCSR_PSW_F0      5
`define CCSR_PSW_RS1     4
`define CCSR_PSW_RS0     3
`define CCSR_PSW_OV      2
`define CCSR_PSW_F1      1
`define CCSR_AUX_UVEN    7
`define CCSR_AUX_UVF     6
`define CCSR_AUX_ITS     4
`define CCSR_AUX_BDBL    3
`define CCSR_AUX_BSRC    2
`define CCSR_AUX_DPS     1
`define CCSR_AUX_LOCK    0
`define CCSR_RST_ITS     1'b1
`define CCSR_RST_LOCK    1'b1
`define CCSR_XRAM_DEPTH  512
`endif

/* File: rtl/ccsr_pkg.sv */
// Types shared by the special register block and its users
package ccsr_pkg;
   // Core-side update requests: one-cycle strobes with their data, index and address-select fields
   typedef struct packed {
      logic        acc_we;
      logic [7:0]  acc_wdata;
      logic        opnd_we;
      logic [7:0]  opnd_wdata;
      logic        cy_we;
      logic        cy_val;
      logic        ac_we;
      logic        ac_val;
      logic        ov_we;
      logic        ov_val;
      logic        push;
      logic        pop;
      logic        dp_we;
      logic [15:0] dp_wdata;
      logic        dp_inc;
      logic        xr_we;
      logic        xr_re;
      logic        xr_use_dp;
      logic [7:0]  xr_ri;
      logic [7:0]  xr_wdata;
   } ccsr_core_op_t;
   // State presented to the core
   typedef struct packed {
      logic [7:0]  acc;
      logic [7:0]  opnd;
      logic [7:0]  processor_status_word;
      logic [7:0]  sp;
      logic [15:0] data_pointer_pair;
      logic [7:0]  bank_base;
      logic [7:0]  xr_rdata;
      logic        timing_2t;
      logic        uv_enable;
      logic        baud_double;
      logic        baud_source;
   } ccsr_view_t;
endpackage

/* File: rtl/ccsr_top.sv */
// Core special registers with APB access
`timescale 1ns/1ps
`include "ccsr_regs.svh"
module ccsr_top (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire ccsr_pkg::ccsr_core_op_t core_op,
   input  wire logic                   undervolt_in,
   input  wire logic                   code_lock_in,
   output ccsr_pkg::ccsr_view_t        core_view
);

   // Odd count of ones gives one
   function automatic logic odd_ones(input logic [7:0] v);
      odd_ones = ^v;
   endfunction

   // Register index decode from a byte address
   function automatic logic idx_is(input logic [11:0] a,
                                   input logic [7:0]  idx);
      idx_is = (a[11:10] == 2'h0) && (a[9:2] == idx)
               && (a[1:0] == 2'h0);
   endfunction

   logic [7:0]  acc_reg;
   logic [7:0]  opnd_reg;
   logic        cy_reg;
   logic        ac_reg;
   logic        f0_reg;
   logic [1:0]  bank_reg;
   logic        ov_reg;
   logic        f1_reg;
   logic [7:0]  sp_reg;
   logic [15:0] dp0_reg;
   logic [15:0] dp1_reg;
   logic        page_reg;
   logic        uven_reg;
   logic        uvf_reg;
   logic        its_reg;
   logic        bdbl_reg;
   logic        bsrc_reg;
   logic        dps_reg;
   logic        lock_reg;
   logic [7:0]  xr_rdata_reg;
   logic [31:0] prdata_reg;
   logic        perr_reg;
   logic [7:0]  psw_view;
   logic [7:0]  aux_view;
   logic [7:0]  rd_byte;
   logic        rd_hit;
   logic        wr;
   logic [7:0]  wb;
   logic [15:0] dp_act;
   logic [8:0]  xr_addr;
   logic [7:0]  xram_mem [`CCSR_XRAM_DEPTH];

   // Write strobe at the completing access edge
   assign wr = psel & penable & pwrite;
   assign wb = pwdata[7:0];

   // Accumulator: core result has priority over a software write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_reg <= `CCSR_RST_ZERO;
      end else if (core_op.acc_we) begin
         acc_reg <= core_op.acc_wdata;
      end else if (wr && idx_is(paddr, `CCSR_IDX_ACC)) begin
         acc_reg <= wb;
      end
   end

   // Operand register for multiply and divide
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opnd_reg <= `CCSR_RST_ZERO;
      end else if (core_op.opnd_we) begin
         opnd_reg <= core_op.opnd_wdata;
      end else if (wr && idx_is(paddr, `CCSR_IDX_OPND)) begin
         opnd_reg <= wb;
      end
   end

   // Arithmetic flags: core updates win over software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cy_reg <= 1'b0;
         ac_reg <= 1'b0;
         ov_reg <= 1'b0;
      end else begin
         if (core_op.cy_we) begin
            cy_reg <= core_op.cy_val;
         end else if (wr && idx_is(paddr, `CCSR_IDX_PSW)) begin
            cy_reg <= wb[`CCSR_PSW_CY];
         end
         if (core_op.ac_we) begin
            ac_reg <= core_op.ac_val;
         end else if (wr && idx_is(paddr, `CCSR_IDX_PSW)) begin
            ac_reg <= wb[`CCSR_PSW_AC];
         end
         if (core_op.ov_we) begin
            ov_reg <= core_op.ov_val;
         end else if (wr && idx_is(paddr, `CCSR_IDX_PSW)) begin
            ov_reg <= wb[`CCSR_PSW_OV];
         end
      end
   end

   // User flags and bank select; parity bit is not stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         f0_reg   <= 1'b0;
         f1_reg   <= 1'b0;
         bank_reg <= 2'h0;
      end else if (wr && idx_is(paddr, `CCSR_IDX_PSW)) begin
         f0_reg   <= wb[`CCSR_PSW_F0];
         f1_reg   <= wb[`CCSR_PSW_F1];
         bank_reg <= wb[`CCSR_PSW_RS1:`CCSR_PSW_RS0];
      end
   end

   // Status word as read; parity follows the accumulator
   assign psw_view = {cy_reg, ac_reg, f0_reg, bank_reg,
                      ov_reg, f1_reg, odd_ones(acc_reg)};

   // Stack pointer: push pre-increments, pop post-decrements
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_reg <= `CCSR_RST_SP;
      end else if (core_op.push) begin
         sp_reg <= sp_reg + 8'h01;
      end else if (core_op.pop) begin
         sp_reg <= sp_reg - 8'h01;
      end else if (wr && idx_is(paddr, `CCSR_IDX_SP)) begin
         sp_reg <= wb;
      end
   end

   // Pointer pairs: core ops touch only the selected pair
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dp0_reg <= 16'h0000;
         dp1_reg <= 16'h0000;
      end else begin
         if (!dps_reg && core_op.dp_we) begin
            dp0_reg <= core_op.dp_wdata;
         end else if (!dps_reg && core_op.dp_inc) begin
            dp0_reg <= dp0_reg + 16'h0001;
         end else if (wr && idx_is(paddr, `CCSR_IDX_POINTER0_LOW_BYTE)) begin
            dp0_reg[7:0] <= wb;
         end else if (wr && idx_is(paddr, `CCSR_IDX_POINTER0_HIGH_BYTE)) begin
            dp0_reg[15:8] <= wb;
         end
         if (dps_reg && core_op.dp_we) begin
            dp1_reg <= core_op.dp_wdata;
         end else if (dps_reg && core_op.dp_inc) begin
            dp1_reg <= dp1_reg + 16'h0001;
         end else if (wr && idx_is(paddr, `CCSR_IDX_POINTER1_LOW_BYTE)) begin
            dp1_reg[7:0] <= wb;
         end else if (wr && idx_is(paddr, `CCSR_IDX_POINTER1_HIGH_BYTE)) begin
            dp1_reg[15:8] <= wb;
         end
      end
   end

   // Active pointer chosen by the select bit
   assign dp_act = dps_reg ? dp1_reg : dp0_reg;

   // Page register keeps only the page bit, so it reads F0H/F1H
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         page_reg <= 1'b0;
      end else if (wr && idx_is(paddr, `CCSR_IDX_PAGE)) begin
         page_reg <= wb[0];
      end
   end

   // Writable control bits of the miscellaneous register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uven_reg <= 1'b0;
         its_reg  <= `CCSR_RST_ITS;
         bdbl_reg <= 1'b0;
         bsrc_reg <= 1'b0;
         dps_reg  <= 1'b0;
      end else if (wr && idx_is(paddr, `CCSR_IDX_AUX)) begin
         uven_reg <= wb[`CCSR_AUX_UVEN];
         its_reg  <= wb[`CCSR_AUX_ITS];
         bdbl_reg <= wb[`CCSR_AUX_BDBL];
         bsrc_reg <= wb[`CCSR_AUX_BSRC];
         dps_reg  <= wb[`CCSR_AUX_DPS];
      end
   end

   // Status bits follow their inputs, the undervolt flag only while enabled; writes never reach them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uvf_reg  <= 1'b0;
         lock_reg <= `CCSR_RST_LOCK;
      end else begin
         uvf_reg  <= undervolt_in & uven_reg;
         lock_reg <= code_lock_in;
      end
   end

   // Bit 5 reads zero
   assign aux_view = {uven_reg, uvf_reg, 1'b0, its_reg,
                      bdbl_reg, bsrc_reg, dps_reg, lock_reg};

   // Expanded RAM: pointer address or page plus 8-bit index
   assign xr_addr = core_op.xr_use_dp ? dp_act[8:0]
                                      : {page_reg, core_op.xr_ri};

   // Expanded RAM storage, reached only from the core port
   always_ff @(posedge pclk) begin
      if (core_op.xr_we) begin
         xram_mem[xr_addr] <= core_op.xr_wdata;
      end
   end

   // Expanded RAM read data, one cycle after the read strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xr_rdata_reg <= 8'h00;
      end else if (core_op.xr_re) begin
         xr_rdata_reg <= xram_mem[xr_addr];
      end
   end

   // Read decode
   always_comb begin
      rd_byte = 8'h00;
      rd_hit  = 1'b1;
      if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0) begin
         rd_hit = 1'b0;
      end else begin
         case (paddr[9:2])
            `CCSR_IDX_SP:   rd_byte = sp_reg;
            `CCSR_IDX_POINTER0_LOW_BYTE: rd_byte = dp0_reg[7:0];
            `CCSR_IDX_POINTER0_HIGH_BYTE: rd_byte = dp0_reg[15:8];
            `CCSR_IDX_POINTER1_LOW_BYTE: rd_byte = dp1_reg[7:0];
            `CCSR_IDX_POINTER1_HIGH_BYTE: rd_byte = dp1_reg[15:8];
            `CCSR_IDX_PAGE: rd_byte = `CCSR_PAGE_BASE | {7'h00, page_reg};
            `CCSR_IDX_AUX:  rd_byte = aux_view;
            `CCSR_IDX_PSW:  rd_byte = psw_view;
            `CCSR_IDX_ACC:  rd_byte = acc_reg;
            `CCSR_IDX_OPND: rd_byte = opnd_reg;
            default:        rd_hit  = 1'b0;
         endcase
      end
   end

   // Read data and error captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
         perr_reg   <= 1'b0;
      end else if (psel && !penable) begin
         prdata_reg <= {24'h00_0000, rd_byte};
         perr_reg   <= ~rd_hit;
      end
   end

   // Zero wait states
   assign pready  = 1'b1;
   assign prdata  = prdata_reg;
   assign pslverr = perr_reg & psel & penable;

   // State offered to the core
   assign core_view.acc         = acc_reg;
   assign core_view.opnd        = opnd_reg;
   assign core_view.processor_status_word         = psw_view;
   assign core_view.sp          = sp_reg;
   assign core_view.data_pointer_pair        = dp_act;
   assign core_view.bank_base   = {3'h0, bank_reg, 3'h0};
   assign core_view.xr_rdata    = xr_rdata_reg;
   assign core_view.timing_2t   = its_reg;
   assign core_view.uv_enable   = uven_reg;
   assign core_view.baud_double = bdbl_reg;
   assign core_view.baud_source = bsrc_reg;

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic sw_psw;
   logic sw_aux;
   assign sw_psw = wr && idx_is(paddr, `CCSR_IDX_PSW);
   assign sw_aux = wr && idx_is(paddr, `CCSR_IDX_AUX);

   sequence s_push;
      core_op.push && !core_op.pop;
   endsequence
   sequence s_pop;
      core_op.pop && !core_op.push;
   endsequence

   property p_acc_write;
      core_op.acc_we |=> acc_reg == $past(core_op.acc_wdata);
   endproperty
   a_acc_write: assert property (p_acc_write)
      else $error("accumulator missed core result");

   property p_opnd_write;
      core_op.opnd_we |=> opnd_reg == $past(core_op.opnd_wdata);
   endproperty
   a_opnd_write: assert property (p_opnd_write)
      else $error("operand register missed core result");

   property p_parity;
      core_op.acc_we |=> core_view.processor_status_word[0] == (^$past(core_op.acc_wdata));
   endproperty
   a_parity: assert property (p_parity)
      else $error("parity bit disagrees with accumulator");

   property p_parity_ro;
      sw_psw && !core_op.acc_we && (wb[0] != odd_ones(acc_reg))
      |=> psw_view[0] == $past(odd_ones(acc_reg));
   endproperty
   a_parity_ro: assert property (p_parity_ro)
      else $error("parity bit took software value");

   property p_carry;
      core_op.cy_we |=> psw_view[`CCSR_PSW_CY] == $past(core_op.cy_val);
   endproperty
   a_carry: assert property (p_carry)
      else $error("carry flag not updated");

   property p_half;
      core_op.ac_we |=> psw_view[`CCSR_PSW_AC] == $past(core_op.ac_val);
   endproperty
   a_half: assert property (p_half)
      else $error("half carry flag not updated");

   property p_ovf;
      core_op.ov_we |=> psw_view[`CCSR_PSW_OV] == $past(core_op.ov_val);
   endproperty
   a_ovf: assert property (p_ovf)
      else $error("overflow flag not updated");

   property p_user;
      sw_psw |=> {psw_view[`CCSR_PSW_F0], psw_view[`CCSR_PSW_F1]}
                 == $past({wb[`CCSR_PSW_F0], wb[`CCSR_PSW_F1]});
   endproperty
   a_user: assert property (p_user)
      else $error("user flags not stored");

   property p_bank;
      sw_psw |=> core_view.bank_base
                 == {3'h0, $past(wb[`CCSR_PSW_RS1:`CCSR_PSW_RS0]), 3'h0};
   endproperty
   a_bank: assert property (p_bank)
      else $error("bank base wrong");

   property p_push_pop;
      s_push ##1 s_pop |=> sp_reg == $past(sp_reg, 2);
   endproperty
   a_push_pop: assert property (p_push_pop)
      else $error("stack pointer not restored by pop");

   property p_push_inc;
      s_push |=> sp_reg == $past(sp_reg) + 8'h01;
   endproperty
   a_push_inc: assert property (p_push_inc)
      else $error("push did not pre-increment");

   property p_dp_sel;
      core_op.dp_inc && !core_op.dp_we
      |=> core_view.data_pointer_pair == $past(dp_act) + 16'h0001
          || $past(sw_aux);
   endproperty
   a_dp_sel: assert property (p_dp_sel)
      else $error("increment missed the selected pointer");

   property p_dp_idle;
      core_op.dp_inc && dps_reg && !wr |=> dp0_reg == $past(dp0_reg);
   endproperty
   a_dp_idle: assert property (p_dp_idle)
      else $error("unselected pointer changed");

   property p_its;
      sw_aux |=> core_view.timing_2t == $past(wb[`CCSR_AUX_ITS]);
   endproperty
   a_its: assert property (p_its)
      else $error("timing select not stored");

   property p_uvf;
      !uven_reg ##1 !uven_reg |-> !uvf_reg;
   endproperty
   a_uvf: assert property (p_uvf)
      else $error("undervolt flag set while disabled");

   property p_aux_ro;
      sw_aux |=> aux_view[5] == 1'b0
                 && lock_reg == $past(code_lock_in);
   endproperty
   a_aux_ro: assert property (p_aux_ro)
      else $error("read-only control bits took a write");

   property p_page;
      wr && idx_is(paddr, `CCSR_IDX_PAGE) |=> page_reg == $past(wb[0]);
   endproperty
   a_page: assert property (p_page)
      else $error("page bit not stored");

endmodule // ccsr_top

/* File: verification/cpu_core_special_registers_bench.sv */
// Self-checking bench for the core special register block
`timescale 1ns/1ps
`include "ccsr_regs.svh"
module cpu_core_special_registers_bench;
   logic                    pclk;
   logic                    presetn;
   logic                    psel;
   logic                    penable;
   logic                    pwrite;
   logic [11:0]             paddr;
   logic [31:0]             pwdata;
   logic [31:0]             prdata;
   logic                    pready;
   logic                    pslverr;
   logic                    undervolt_in;
   logic                    code_lock_in;
   ccsr_pkg::ccsr_core_op_t core_op;
   ccsr_pkg::ccsr_core_op_t op;
   ccsr_pkg::ccsr_view_t    core_view;
   logic [32:0]             note_q[$];
   logic [7:0]              wv[7];
   logic [7:0]              v;
   logic [7:0]              a;
   int                      failures;
   int                      samples_checked;
   int                      seed;
   logic [7:0] ix[10] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86,
                          8'h8E, 8'hD0, 8'hE0, 8'hF0};
   logic [7:0] rv[10] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'hF0,
                          8'h11, 8'h00, 8'h00, 8'h00};

   ccsr_top dut_u (
      .pclk         (pclk),
      .presetn      (presetn),
      .psel         (psel),
      .penable      (penable),
      .pwrite       (pwrite),
      .paddr        (paddr),
      .pwdata       (pwdata),
      .prdata       (prdata),
      .pready       (pready),
      .pslverr      (pslverr),
      .core_op      (core_op),
      .undervolt_in (undervolt_in),
      .code_lock_in (code_lock_in),
      .core_view    (core_view)
   );

   // Clock at 50 MHz
   always #10 pclk = ~pclk;

   // Compares one value and counts it
   task automatic chk(input string nm, input logic [32:0] e,
                      input logic [32:0] s);
      samples_checked++;
      if (s !== e) begin
         failures++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask

   // Prints the verdict and stops
   task automatic tally_and_finish;
      if (note_q.size() != 0) failures++;
      if (failures == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // One APB transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] ad,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= ad;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         failures++;
         tally_and_finish();
      end
      #1;
   endtask

   // Register write by index
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, {2'b00, idx, 2'b00}, {24'h000000, d});
   endtask

   // Read at a raw address, noting error flag and data expected
   task automatic rdx(input logic [11:0] ad, input logic [32:0] e);
      note_q.push_back(e);
      apb(1'b0, ad, 32'h00000000);
   endtask

   // Register read by index
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      rdx({2'b00, idx, 2'b00}, {1'b0, 24'h000000, e});
   endtask

   // One-cycle core strobe, then let the update settle
   task automatic pulse;
      @(posedge pclk);
      core_op <= op;
      @(posedge pclk);
      core_op <= '0;
      #1;
   endtask

   // Read monitor: takes the oldest note at each completed read
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1
          && pwrite === 1'b0) begin
         if (note_q.size() == 0) begin
            chk("read note", 33'h0, {pslverr, prdata});
         end else begin
            chk("read", note_q.pop_front(), {pslverr, prdata});
         end
      end
   end

   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      core_op = '0;
      op = '0;
      undervolt_in = 1'b0;
      code_lock_in = 1'b1;
      failures = 0;
      samples_checked = 0;
      seed = 35;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values of every register
      for (int i = 0; i < 10; i++) rd(ix[i], rv[i]);
      // Unmapped and misaligned reads are refused
      rdx(12'h000, {1'b1, 32'h0});
      rdx(12'h205, {1'b1, 32'h0});
      // Random write and read back of plain registers
      for (int i = 0; i < 7; i++) begin
         wv[i] = 8'($random(seed));
         wr(ix[(i < 2) ? i + 8 : i - 2], wv[i]);
         rd(ix[(i < 2) ? i + 8 : i - 2], wv[i]);
      end
      chk("acc", wv[0], core_view.acc);
      chk("opnd", wv[1], core_view.opnd);
      // Parity follows the accumulator
      for (int i = 0; i < 4; i++) begin
         a = 8'($random(seed));
         wr(`CCSR_IDX_ACC, a);
         rd(`CCSR_IDX_PSW, {7'h00, ^a});
      end
      // Parity ignores writes, user flags store
      wr(`CCSR_IDX_PSW, 8'hFF);
      rd(`CCSR_IDX_PSW, {7'h7F, ^a});
      wr(`CCSR_IDX_PSW, 8'h00);
      rd(`CCSR_IDX_PSW, {7'h00, ^a});
      for (int i = 0; i < 4; i++) begin
         wr(`CCSR_IDX_PSW, {3'b000, i[1:0], 3'b000});
         chk("bank_base", {3'b000, i[1:0], 3'b000}, core_view.bank_base);
      end
      wr(`CCSR_IDX_PSW, 8'h00);
      // Core flag and accumulator updates
      op.acc_we = 1'b1;
      op.acc_wdata = 8'h07;
      op.cy_we = 1'b1;
      op.cy_val = 1'b1;
      op.ac_we = 1'b1;
      op.ac_val = 1'b1;
      op.ov_we = 1'b1;
      op.ov_val = 1'b1;
      pulse();
      chk("psw", 8'hC5, core_view.processor_status_word);
      rd(`CCSR_IDX_ACC, 8'h07);
      rd(`CCSR_IDX_PSW, 8'hC5);
      op = '0;
      op.cy_we = 1'b1;
      pulse();
      rd(`CCSR_IDX_PSW, 8'h45);
      // Stack pointer moves on push and pop
      wr(`CCSR_IDX_SP, 8'h07);
      op = '0;
      op.push = 1'b1;
      pulse();
      chk("sp", 8'h08, core_view.sp);
      op.pop = 1'b1;
      pulse();
      chk("sp", 8'h09, core_view.sp);
      op.push = 1'b0;
      pulse();
      rd(`CCSR_IDX_SP, 8'h08);
      // Push then pop on the next cycle restores the pointer
      op = '0;
      op.push = 1'b1;
      @(posedge pclk);
      core_op <= op;
      op = '0;
      op.pop = 1'b1;
      pulse();
      chk("sp", 8'h08, core_view.sp);
      // Second pointer selected, loaded and stepped
      wr(`CCSR_IDX_AUX, 8'h02);
      op = '0;
      op.dp_we = 1'b1;
      op.dp_wdata = 16'hA5FF;
      pulse();
      chk("data_pointer_pair", 16'hA5FF, core_view.data_pointer_pair);
      op = '0;
      op.dp_inc = 1'b1;
      pulse();
      rd(`CCSR_IDX_POINTER1_LOW_BYTE, 8'h00);
      rd(`CCSR_IDX_POINTER1_HIGH_BYTE, 8'hA6);
      rd(`CCSR_IDX_POINTER0_LOW_BYTE, wv[3]);
      wr(`CCSR_IDX_AUX, 8'h00);
      chk("data_pointer_pair", {wv[4], wv[3]}, core_view.data_pointer_pair);
      // Control bits, read-only status and reserved bit
      @(posedge pclk);
      undervolt_in <= 1'b1;
      code_lock_in <= 1'b0;
      wr(`CCSR_IDX_AUX, 8'hFF);
      rd(`CCSR_IDX_AUX, 8'hDE);
      chk("ctl", 4'hF, {core_view.timing_2t, core_view.uv_enable,
          core_view.baud_double, core_view.baud_source});
      @(posedge pclk);
      code_lock_in <= 1'b1;
      wr(`CCSR_IDX_AUX, 8'h00);
      rd(`CCSR_IDX_AUX, 8'h01);
      chk("ctl", 4'h0, {core_view.timing_2t, core_view.uv_enable,
          core_view.baud_double, core_view.baud_source});
      // Expanded RAM, page one by short address, back by pointer
      wr(`CCSR_IDX_PAGE, 8'hF1);
      rd(`CCSR_IDX_PAGE, 8'hF1);
      v = 8'($random(seed));
      op = '0;
      op.xr_we = 1'b1;
      op.xr_ri = 8'h3C;
      op.xr_wdata = v;
      pulse();
      op = '0;
      op.dp_we = 1'b1;
      op.dp_wdata = 16'h013C;
      pulse();
      op = '0;
      op.xr_re = 1'b1;
      op.xr_use_dp = 1'b1;
      pulse();
      chk("xr_rdata", v, core_view.xr_rdata);
      wr(`CCSR_IDX_PAGE, 8'h00);
      rd(`CCSR_IDX_PAGE, 8'hF0);
      // Mid-run reset brings every register back
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 10; i++) rd(ix[i], rv[i]);
      tally_and_finish();
   end
endmodule // cpu_core_special_registers_bench
